//--- src/slot_scan_pkg.sv
package slot_scan_pkg;

  // ------------------------------------------------------------
  // Slot numbering, in scan order
  // ------------------------------------------------------------
  localparam int          SLOT_COUNT = 7;
  localparam logic [2:0]  SLOT_CPU   = 3'h0;
  localparam logic [2:0]  SLOT_A     = 3'h1;
  localparam logic [2:0]  SLOT_B     = 3'h2;
  localparam logic [2:0]  SLOT_C     = 3'h3;
  localparam logic [2:0]  SLOT_D     = 3'h4;
  localparam logic [2:0]  SLOT_E     = 3'h5;
  localparam logic [2:0]  SLOT_F     = 3'h6;

  // ------------------------------------------------------------
  // Designation numbering
  // ------------------------------------------------------------
  localparam logic [5:0]  CPU_DI_FIRST   = 6'h01;
  localparam logic [3:0]  CPU_DI_COUNT   = 4'h3;
  localparam logic [5:0]  CPU_DO_FIRST   = 6'h01;
  localparam logic [3:0]  CPU_DO_COUNT   = 4'h5;
  localparam logic [3:0]  CPU_PORT_FIRST = 4'h1;
  localparam logic [3:0]  CPU_PORT_COUNT = 4'h2;
  localparam logic [5:0]  ADD_DI_FIRST   = 6'h04;
  localparam logic [5:0]  ADD_DO_FIRST   = 6'h06;
  localparam logic [3:0]  ADD_PORT_FIRST = 4'h3;
  localparam logic [3:0]  EIGHT_IN_COUNT = 4'h8;
  localparam logic [3:0]  FIVE_OUT_COUNT = 4'h5;
  localparam logic [3:0]  CT_CHAN_COUNT  = 4'h5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS     = 1000;
  localparam int SETTLE_CYC    =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    KIND_NONE,
    KIND_EIGHT_IN,
    KIND_FIVE_OUT,
    KIND_COMM,
    KIND_CT,
    KIND_OTHER
  } card_kind_e;

  typedef struct packed {
    logic       present;
    card_kind_e kind;
    logic       code_ok;
  } card_probe_s;

  typedef struct packed {
    card_kind_e kind;
    logic       alarm;
    logic [5:0] di_first;
    logic [3:0] di_count;
    logic [5:0] do_first;
    logic [3:0] do_count;
    logic [3:0] port;
  } slot_rec_s;

  localparam int REC_W = $bits(slot_rec_s);

endpackage

//--- src/slot_table.sv
`timescale 1ns/10ps
module slot_table #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 8,
  parameter int AW    = 3
) (
  // Clock
  input  wire logic             core_clk,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; a record is valid once its slot is scanned
  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

//--- src/tcs_gate.sv
`timescale 1ns/10ps
module tcs_gate (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic nrst,
  // Pins
  input  wire logic breaker_closed,
  input  wire logic trip_circuit_supervision_input,
  // Alarm
  output logic      tcs_alarm
);

  logic [1:0] closed_sync;
  logic [1:0] sup_sync;

  // Two-stage synchronisers for both pins
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      closed_sync <= 2'h0;
      sup_sync    <= 2'h3;
    end
    else
    begin
      closed_sync <= {closed_sync[0], breaker_closed};
      sup_sync    <= {sup_sync[0], trip_circuit_supervision_input};
    end
  end

  // Open breaker blocks the alarm; input is normally closed
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tcs_alarm <= 1'b0;
    end
    else
    begin
      tcs_alarm <= closed_sync[1] & ~sup_sync[1];
    end
  end

endmodule

//--- src/io_slot_scan.sv
// Behaviour
// - The supervision alarm is on only with breaker closed and input off.
// - The scan visits the CPU module, then Slots A to F in turn; only A, C, E and F add I/O.
// - The first pass self-tests the CPU, giving it inputs 1-3, outputs 1-5.
// - An empty Slot A is skipped; an eight-input card there takes 4-11.
// - A five-output card in Slot A takes outputs 6-10.
// - I/O is added only for a matching card; a mismatch or a missing expected card alarms.
// - Any card in Slot B raises an alarm.
// - An eight-input card in Slot C takes 4-11, or 12-19 after Slot A.
// - A five-output card in Slot C takes 6-10, or 11-15 after Slot A.
// - Slot D must hold the five-channel current card, else an alarm.
// - Slots E and F number new channels after those already reserved.
// - Any unexpected module content raises a configuration error.
// - Added communication ports are numbered from 3 upward.
// - A detected port is enabled in the communication space.
// - Communication cards are accepted only in Slots E and F.
`timescale 1ns/10ps
module io_slot_scan #(
  parameter int SETTLE = slot_scan_pkg::SETTLE_CYC
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  // Scan control and expected fit-out
  input  wire logic                     scan_start,
  input  wire logic [20:0]              expected_cfg,
  // Card probe pins
  output logic                          probe_req,
  output logic [2:0]                    probe_slot,
  input  wire slot_scan_pkg::card_probe_s probe_pins,
  input  wire logic                     cpu_selftest_ok,
  // Trip circuit supervision
  input  wire logic                     breaker_closed,
  input  wire logic                     trip_circuit_supervision_input,
  output logic                          tcs_alarm,
  // Results
  output logic                          scan_busy,
  output logic                          scan_done,
  output logic                          config_error,
  output logic [6:0]                    slot_alarm,
  output logic [5:0]                    di_total,
  output logic [5:0]                    do_total,
  output logic [15:0]                   port_enable,
  // Record lookup
  input  wire logic [2:0]               rec_addr,
  output slot_scan_pkg::slot_rec_s      rec_data
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] di_of(slot_scan_pkg::card_kind_e k);
    di_of = (k == slot_scan_pkg::KIND_EIGHT_IN) ?
            slot_scan_pkg::EIGHT_IN_COUNT : 4'h0;
  endfunction

  function automatic logic [3:0] do_of(slot_scan_pkg::card_kind_e k);
    do_of = (k == slot_scan_pkg::KIND_FIVE_OUT) ?
            slot_scan_pkg::FIVE_OUT_COUNT : 4'h0;
  endfunction

  function automatic slot_scan_pkg::card_kind_e exp_of(
    logic [20:0] cfg,
    logic [2:0]  slot
  );
    exp_of = slot_scan_pkg::card_kind_e'(cfg[slot*3 +: 3]);
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PROBE,
    ST_EVAL,
    ST_DONE
  } scan_state_e;

  scan_state_e                state_reg;
  scan_state_e                state_next;
  logic [2:0]                 slot_reg;
  logic [7:0]                 wait_reg;
  logic [5:0]                 di_next_reg;
  logic [5:0]                 do_next_reg;
  logic [3:0]                 port_next_reg;
  logic [15:0]                port_en_reg;
  logic [6:0]                 alarm_reg;
  slot_scan_pkg::card_probe_s probe_s1;
  slot_scan_pkg::card_probe_s probe_s2;
  logic [1:0]                 cpu_ok_sync;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Card pins settle during the probe wait, so a bus sync is safe
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      probe_s1    <= '0;
      probe_s2    <= '0;
      cpu_ok_sync <= 2'h0;
    end
    else
    begin
      probe_s1    <= probe_pins;
      probe_s2    <= probe_s1;
      cpu_ok_sync <= {cpu_ok_sync[0], cpu_selftest_ok};
    end
  end

  // ------------------------------------------------------------
  // Slot evaluation
  // ------------------------------------------------------------
  wire slot_scan_pkg::card_kind_e seen_kind =
    probe_s2.present ? probe_s2.kind : slot_scan_pkg::KIND_NONE;
  wire slot_scan_pkg::card_kind_e exp_kind = exp_of(expected_cfg, slot_reg);
  wire is_cpu     = (slot_reg == slot_scan_pkg::SLOT_CPU);
  wire is_comm_ok = (slot_reg == slot_scan_pkg::SLOT_E) ||
                    (slot_reg == slot_scan_pkg::SLOT_F);

  // Slot B must stay empty whatever the expected table claims
  wire b_occupied = (slot_reg == slot_scan_pkg::SLOT_B) &&
                    probe_s2.present;
  // Slot D must carry the current card whatever the expected table claims
  wire d_no_ct    = (slot_reg == slot_scan_pkg::SLOT_D) &&
                    (seen_kind != slot_scan_pkg::KIND_CT);
  wire comm_bad   = (seen_kind == slot_scan_pkg::KIND_COMM) &&
                    !is_comm_ok;
  // Wrong type, bad code or missing expected card
  wire mismatch   = (seen_kind != exp_kind) ||
                    (probe_s2.present && !probe_s2.code_ok);
  wire slot_alarm_w = is_cpu ? !cpu_ok_sync[1] :
                      (mismatch | b_occupied | d_no_ct | comm_bad);
  // Empty slots and alarmed cards add nothing, the scan moves on
  wire accept     = !is_cpu && probe_s2.present && !slot_alarm_w;

  wire [3:0] add_di   = accept ? di_of(seen_kind) : 4'h0;
  wire [3:0] add_do   = accept ? do_of(seen_kind) : 4'h0;
  wire       add_port = accept &&
                        (seen_kind == slot_scan_pkg::KIND_COMM);

  // Record for this slot: CPU gets fixed designations
  slot_scan_pkg::slot_rec_s rec_w;
  always_comb
  begin
    rec_w       = '0;
    rec_w.kind  = seen_kind;
    rec_w.alarm = slot_alarm_w;
    if (is_cpu)
    begin
      rec_w.kind     = slot_scan_pkg::KIND_OTHER;
      rec_w.di_first = slot_scan_pkg::CPU_DI_FIRST;
      rec_w.di_count = slot_scan_pkg::CPU_DI_COUNT;
      rec_w.do_first = slot_scan_pkg::CPU_DO_FIRST;
      rec_w.do_count = slot_scan_pkg::CPU_DO_COUNT;
      rec_w.port     = slot_scan_pkg::CPU_PORT_FIRST;
    end
    else
    begin
      // Counters already hold what earlier slots reserved
      rec_w.di_first = di_next_reg;
      rec_w.di_count = add_di;
      rec_w.do_first = do_next_reg;
      rec_w.do_count = add_do;
      rec_w.port     = add_port ? port_next_reg : 4'h0;
    end
  end

  // ------------------------------------------------------------
  // Scan sequencer
  // ------------------------------------------------------------
  wire settle_done = (wait_reg == 8'(SETTLE - 1));
  wire last_slot   = (slot_reg == 3'(slot_scan_pkg::SLOT_COUNT - 1));

  // One slot is finished completely before the next is probed
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:  if (scan_start) state_next = ST_PROBE;
      ST_PROBE: if (settle_done) state_next = ST_EVAL;
      ST_EVAL:  state_next = last_slot ? ST_DONE : ST_PROBE;
      ST_DONE:  if (scan_start) state_next = ST_PROBE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // Slot pointer and settle timer
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      slot_reg <= slot_scan_pkg::SLOT_CPU;
      wait_reg <= 8'h00;
    end
    else if (state_reg != ST_PROBE && state_next == ST_PROBE &&
             state_reg != ST_EVAL)
    begin
      slot_reg <= slot_scan_pkg::SLOT_CPU;
      wait_reg <= 8'h00;
    end
    else if (state_reg == ST_PROBE)
    begin
      wait_reg <= settle_done ? 8'h00 : wait_reg + 8'h01;
    end
    else if (state_reg == ST_EVAL && !last_slot)
    begin
      slot_reg <= slot_reg + 3'h1;
    end
  end

  // ------------------------------------------------------------
  // Designation counters and port space
  // ------------------------------------------------------------
  wire scan_launch = scan_start &&
                     (state_reg == ST_IDLE || state_reg == ST_DONE);

  // A new scan rebuilds everything from the CPU module up
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      di_next_reg   <= slot_scan_pkg::ADD_DI_FIRST;
      do_next_reg   <= slot_scan_pkg::ADD_DO_FIRST;
      port_next_reg <= slot_scan_pkg::ADD_PORT_FIRST;
      port_en_reg   <= 16'h0000;
      alarm_reg     <= 7'h00;
    end
    else if (scan_launch)
    begin
      di_next_reg   <= slot_scan_pkg::ADD_DI_FIRST;
      do_next_reg   <= slot_scan_pkg::ADD_DO_FIRST;
      port_next_reg <= slot_scan_pkg::ADD_PORT_FIRST;
      port_en_reg   <= 16'h0000;
      alarm_reg     <= 7'h00;
    end
    else if (state_reg == ST_EVAL)
    begin
      di_next_reg <= di_next_reg + {2'h0, add_di};
      do_next_reg <= do_next_reg + {2'h0, add_do};
      alarm_reg[slot_reg] <= slot_alarm_w;
      if (is_cpu)
      begin
        // Ports one and two always belong to the CPU module
        port_en_reg[1] <= 1'b1;
        port_en_reg[2] <= 1'b1;
      end
      else if (add_port)
      begin
        port_en_reg[port_next_reg] <= 1'b1;
        port_next_reg <= port_next_reg + 4'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Record store
  // ------------------------------------------------------------
  slot_table #(
    .WIDTH (slot_scan_pkg::REC_W),
    .DEPTH (8),
    .AW    (3)
  ) u_table (
    .core_clk (core_clk),
    .wr_en    (state_reg == ST_EVAL),
    .wr_addr  (slot_reg),
    .wr_data  (rec_w),
    .rd_addr  (rec_addr),
    .rd_data  (rec_data)
  );

  // ------------------------------------------------------------
  // Trip circuit supervision
  // ------------------------------------------------------------
  tcs_gate u_tcs (
    .core_clk                       (core_clk),
    .nrst                           (nrst),
    .breaker_closed                 (breaker_closed),
    .trip_circuit_supervision_input (trip_circuit_supervision_input),
    .tcs_alarm                      (tcs_alarm)
  );

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Totals count the highest designation handed out so far
  assign probe_req    = (state_reg == ST_PROBE);
  assign probe_slot   = slot_reg;
  assign scan_busy    = (state_reg == ST_PROBE) || (state_reg == ST_EVAL);
  assign scan_done    = (state_reg == ST_DONE);
  assign slot_alarm   = alarm_reg;
  assign config_error = scan_done && (alarm_reg != 7'h00);
  assign di_total     = di_next_reg - 6'h01;
  assign do_total     = do_next_reg - 6'h01;
  assign port_enable  = port_en_reg;

endmodule

//--- test/io_slot_scan_chk.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Checker on the scan block ports
// ------------------------------------------------------------
module io_slot_scan_chk #(
  parameter int SETTLE = slot_scan_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // Scan
  input wire logic        scan_start,
  input wire logic        probe_req,
  input wire logic [2:0]  probe_slot,
  input wire logic        scan_busy,
  input wire logic        scan_done,
  input wire logic        config_error,
  input wire logic [6:0]  slot_alarm,
  input wire logic [5:0]  di_total,
  input wire logic [5:0]  do_total,
  input wire logic [15:0] port_enable,
  // Supervision
  input wire logic        breaker_closed,
  input wire logic        trip_circuit_supervision_input,
  input wire logic        tcs_alarm
);
  // Done state is entered on the last slot's edge, seen one sample later
  localparam int DONE_CYC = 7 * (SETTLE + 1) + 1;
  logic [7:0] run_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  // Length of the running probe window; counted, since SETTLE is a parameter
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      run_reg <= 8'h00;
    else if (probe_req)
      run_reg <= run_reg + 8'h01;
    else
      run_reg <= 8'h00;
  end

  // Pins pass two sync flops and one register, so four steady cycles
  tcs_open_off_a: assert property (
    (!breaker_closed)[*4] |-> !tcs_alarm) else $error("alarm, breaker open");
  tcs_fault_on_a: assert property (
    (breaker_closed && !trip_circuit_supervision_input)[*4] |-> tcs_alarm)
    else $error("no alarm on broken trip circuit");
  launch_cpu_a: assert property (
    scan_start && !scan_busy |=> probe_req && probe_slot == 3'h0)
    else $error("scan did not open on the cpu slot");
  slot_step_a: assert property (
    scan_busy && !$rose(scan_busy) && $changed(probe_slot)
    |-> probe_slot == 3'($past(probe_slot) + 3'h1))
    else $error("slot order broken");
  probe_len_a: assert property (
    $fell(probe_req) |-> run_reg == 8'(SETTLE)) else $error("probe length");
  slot_hold_a: assert property (
    probe_req && $past(probe_req) |-> $stable(probe_slot))
    else $error("slot moved while probing");
  done_time_a: assert property (
    scan_start && !scan_busy |-> ##DONE_CYC scan_done)
    else $error("scan end late or early");
  cfg_err_a: assert property (
    config_error == (scan_done && (|slot_alarm)))
    else $error("configuration error flag wrong");
  di_step_a: assert property (
    scan_busy && !$rose(scan_busy) && $changed(di_total)
    |-> di_total == $past(di_total) + 6'h08) else $error("input step");
  do_step_a: assert property (
    scan_busy && !$rose(scan_busy) && $changed(do_total)
    |-> do_total == $past(do_total) + 6'h05) else $error("output step");
  port_slot_a: assert property (
    $changed(port_enable[15:3]) && !$rose(scan_busy)
    |-> probe_slot inside {3'h5, 3'h6} ||
        $past(probe_slot) inside {3'h5, 3'h6})
    else $error("port added outside the option slots");

  // Main scenarios
  cov_err_c:  cover property (scan_done && config_error);
  cov_ok_c:   cover property (scan_done && !config_error);
  cov_port_c: cover property ($changed(port_enable[15:3]));
  cov_tcs_c:  cover property (tcs_alarm);
endmodule

bind io_slot_scan io_slot_scan_chk #(.SETTLE(SETTLE)) i_io_slot_scan_chk (
  .core_clk, .nrst, .scan_start, .probe_req, .probe_slot, .scan_busy,
  .scan_done, .config_error, .slot_alarm, .di_total, .do_total,
  .port_enable, .breaker_closed, .trip_circuit_supervision_input,
  .tcs_alarm);

//--- test/card_rack.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Card rack behind the probe pins
// ------------------------------------------------------------
module card_rack (
  // Clock
  input  wire logic                            core_clk,
  // Probe side
  input  wire logic [2:0]                      probe_slot,
  output slot_scan_pkg::card_probe_s           probe_pins,
  // Fit-out and pace
  input  wire slot_scan_pkg::card_probe_s [6:0] cards,
  input  wire logic                            slow
);
  logic [2:0] last_reg = 3'h0;
  logic [1:0] age_reg  = 2'h0;
  logic       moved;
  logic       stale;

  // A slow rack settles two cycles after the slot moves; meanwhile the
  // pins show the inverse, so stale data never looks like a valid card
  assign moved      = probe_slot != last_reg;
  assign stale      = slow && (moved || age_reg == 2'h0);
  assign probe_pins = stale ?
    slot_scan_pkg::card_probe_s'(~cards[probe_slot]) : cards[probe_slot];

  // Age of the current slot selection
  always_ff @(posedge core_clk)
  begin
    last_reg <= probe_slot;
    if (moved)
      age_reg <= 2'h0;
    else if (age_reg != 2'h3)
      age_reg <= age_reg + 2'h1;
  end
endmodule

//--- test/tb_top.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Scan block bench
// ------------------------------------------------------------
module tb_top;
  // Slow rack needs two cycles plus two sync stages inside the probe wait
  localparam int SETTLE   = 4;
  localparam int SCAN_CYC = 7 * (SETTLE + 1);
  logic core_clk = 1'b0;
  logic nrst, scan_start, cpu_selftest_ok, slow;
  logic breaker_closed, trip_circuit_supervision_input;
  logic [20:0] expected_cfg;
  logic [2:0]  rec_addr;
  slot_scan_pkg::card_probe_s [6:0] cards;
  slot_scan_pkg::card_probe_s       probe_pins;
  slot_scan_pkg::slot_rec_s         rec_data;
  logic probe_req, tcs_alarm, scan_busy, scan_done, config_error;
  logic [2:0]  probe_slot;
  logic [6:0]  slot_alarm, ex_al;
  logic [5:0]  di_total, do_total;
  logic [15:0] port_enable, ex_pe;
  int fails, check_count, ex_di, ex_do;
  int dif[7], dic[7], dof[7], doc[7], pts[7];

  always #50 core_clk = ~core_clk;

  io_slot_scan #(.SETTLE(SETTLE)) i_io_slot_scan (
    .core_clk, .nrst, .scan_start, .expected_cfg, .probe_req, .probe_slot,
    .probe_pins, .cpu_selftest_ok, .breaker_closed,
    .trip_circuit_supervision_input, .tcs_alarm, .scan_busy, .scan_done,
    .config_error, .slot_alarm, .di_total, .do_total, .port_enable,
    .rec_addr, .rec_data);
  card_rack i_card_rack (.core_clk, .probe_slot, .probe_pins, .cards, .slow);

  // Compare and count
  task automatic chk(input logic [27:0] seen, input logic [27:0] want);
    check_count++;
    if (seen !== want)
    begin
      fails++;
      $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Fit one slot and its expected kind
  task automatic put(input int s, input int k, input int e, input bit ok);
    cards[s].present <= (k != 0);
    cards[s].kind <= slot_scan_pkg::card_kind_e'(k);
    cards[s].code_ok <= ok;
    expected_cfg[3*s+:3] <= 3'(e);
  endtask

  // Random fit-out; B should stay empty and D should hold the current card
  task automatic rnd_fit;
    int k;
    for (int s = 1; s < 7; s++)
    begin
      k = $urandom % 6;
      if (s == 2)
        k = ($urandom % 4 == 0) ? 5 : 0;
      if (s == 4)
        k = ($urandom % 5 == 0) ? 0 : 4;
      put(s, k, ($urandom % 8 == 0) ? $urandom % 6 :
        (s == 2) ? 0 : (s == 4) ? 4 : k, $urandom % 8 != 0);
    end
    cpu_selftest_ok <= ($urandom % 6 != 0);
    slow <= $urandom % 2;
  endtask

  // Reference numbering: running counters, alarmed cards add nothing
  task automatic ref_scan;
    int di, dn, pt, k;
    logic bad;
    di = 4;
    dn = 6;
    pt = 3;
    ex_pe = 16'h0006;
    ex_al = 7'h00;
    ex_al[0] = !cpu_selftest_ok;
    dic[0] = 3;
    doc[0] = 5;
    dif[0] = 1;
    dof[0] = 1;
    for (int s = 1; s < 7; s++)
    begin
      k = cards[s].kind;
      bad = (k != expected_cfg[3*s+:3]) || (s == 2 && cards[s].present)
        || (cards[s].present && !cards[s].code_ok) || (s == 4 && k != 4)
        || (k == 3 && s < 5);
      ex_al[s] = bad;
      dif[s] = di;
      dof[s] = dn;
      dic[s] = (!bad && k == 1) ? 8 : 0;
      doc[s] = (!bad && k == 2) ? 5 : 0;
      pts[s] = (!bad && k == 3) ? pt : 0;
      di += dic[s];
      dn += doc[s];
      if (pts[s] != 0)
      begin
        ex_pe[pt] = 1'b1;
        pt++;
      end
    end
    ex_di = di - 1;
    ex_do = dn - 1;
  endtask

  // One scan, a refused restart in the middle, then every result
  task automatic scan;
    int n;
    @(posedge core_clk);
    scan_start <= 1'b1;
    @(posedge core_clk);
    scan_start <= 1'b0;
    n = 0;
    while (n < 200)
    begin
      @(posedge core_clk);
      n++;
      scan_start <= (n == 5);
      #1;
      if (scan_done)
        break;
    end
    ref_scan();
    chk(n, SCAN_CYC);
    chk(slot_alarm, ex_al);
    chk(slot_alarm[2], ex_al[2]);
    chk(slot_alarm[4], ex_al[4]);
    chk(config_error, |ex_al);
    chk(di_total, ex_di);
    chk(do_total, ex_do);
    chk(port_enable, ex_pe);
    for (int s = 0; s < 7; s++)
    begin
      @(posedge core_clk);
      rec_addr <= 3'(s);
      @(posedge core_clk);
      #1;
      chk(rec_data.alarm, ex_al[s]);
      if (!ex_al[s])
      begin
        chk(rec_data.di_count, dic[s]);
        chk(rec_data.do_count, doc[s]);
        if (dic[s] != 0) chk(rec_data.di_first, dif[s]);
        if (doc[s] != 0) chk(rec_data.do_first, dof[s]);
        if (pts[s] != 0) chk(rec_data.port, pts[s]);
      end
    end
  endtask

  // Main sequence
  initial
  begin
    fails = 0;
    check_count = 0;
    nrst = 1'b0;
    scan_start = 1'b0;
    expected_cfg = 21'h0;
    cpu_selftest_ok = 1'b1;
    breaker_closed = 1'b0;
    trip_circuit_supervision_input = 1'b1;
    rec_addr = 3'h0;
    slow = 1'b0;
    cards = '0;
    void'($urandom(21));
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge core_clk);
      {breaker_closed, trip_circuit_supervision_input} <= 2'(i);
      repeat (4) @(posedge core_clk);
      #1;
      chk(tcs_alarm, i == 2);
    end
    // Eight-input cards in Slots A, C, E and F, current card in D: inputs run to the last number
    @(posedge core_clk);
    put(1, 1, 1, 1); put(3, 1, 1, 1); put(4, 4, 4, 1);
    put(5, 1, 1, 1); put(6, 1, 1, 1);
    scan();
    // Outputs in A and C, ports in E and F, with a slow rack
    @(posedge core_clk);
    put(1, 2, 2, 1); put(3, 2, 2, 1); put(5, 3, 3, 1); put(6, 3, 3, 1);
    slow <= 1'b1;
    scan();
    // Missing card, bad code, B occupied, port card in C, D empty
    @(posedge core_clk);
    put(1, 0, 1, 1); put(2, 5, 0, 1); put(3, 3, 3, 1);
    put(4, 0, 4, 1); put(5, 1, 1, 0);
    scan();
    repeat (12)
    begin
      @(posedge core_clk);
      rnd_fit();
      scan();
    end
    // Reset in mid-scan, then a clean rescan
    @(posedge core_clk);
    scan_start <= 1'b1;
    @(posedge core_clk);
    scan_start <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk({scan_busy, scan_done, di_total, do_total}, 14'h00c5);
    nrst <= 1'b1;
    scan();
    give_verdict();
  end

  // Hang guard, well beyond the expected run
  initial
  begin
    repeat (30 * SCAN_CYC * 20) @(posedge core_clk);
    fails++;
    give_verdict();
  end
endmodule
